// ===== rtl/meter_reset_ctrl.sv
// Reset sequencing, serial port default, gain decode, converter power
// gating, modulator clock and bit-stream averaging for a polyphase meter.
// Assumes reset_n_pin_i and slave_select_pin_i arrive from pins; all
// host writes come as one-cycle strobes from the serial port logic.
`timescale 1ns/1ps

// How it works
// [RULE1] Low reset pin resets only in full power
// [RULE2] Reset pin ignored outside full power mode
// [RULE3] Pin low 10us, then defaults everywhere
// [RULE4] Done flag zero in transition, then set
// [RULE5] Writing one to done flag clears it
// [RULE6] Processor idle after hardware reset
// [RULE7] I2C active after any reset; a locked SPI choice stays active through soft reset
// [RULE8] Host initialises, then starts processor
// [RULE9] Soft reset bit starts software reset
// [RULE10] Soft reset keeps lock and threshold
// [RULE11] Locked port choice survives soft reset
// [RULE12] Soft reset end clears bit, sets flag
// [RULE13] Processor idle; soft reset needs full power
// [RULE14] Phase current gain in bits 2:0
// [RULE15] Neutral gain in bits 5:3
// [RULE16] Voltage gain in bits 8:6
// [RULE17] Converter power follows power mode
// [RULE18] Modulator clock is master clock over 16
// [RULE19] Filter averages stream to 24-bit words
// [RULE20] Host toggles slave select three times
// [RULE21] Done flag unmaskable; pin low until cleared
// [RULE22] Gain codes 0..4 select 1..16
module meter_reset_ctrl #(
    parameter int unsigned RESET_LOW_CYC = meter_reset_pkg::RESET_LOW_MIN_CYC,
    parameter int unsigned TRANS_CYC     = meter_reset_pkg::TRANSITION_CYC
) (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rst_i,
    input  wire logic                          reset_n_pin_i,
    input  wire logic                          slave_select_pin_i,
    input  wire meter_reset_pkg::power_mode_e  power_mode_i,
    input  wire logic                          soft_reset_wr_i,
    input  wire logic                          soft_reset_data_i,
    input  wire logic                          status_wr_i,
    input  wire logic [15:0]                   status_data_i,
    input  wire logic                          port_lock_wr_i,
    input  wire logic [7:0]                    port_lock_data_i,
    input  wire logic                          threshold_wr_i,
    input  wire logic [15:0]                   threshold_data_i,
    input  wire logic                          gain_wr_i,
    input  wire logic [8:0]                    gain_data_i,
    input  wire logic                          run_wr_i,
    input  wire logic                          run_data_i,
    input  wire logic                          mod_bit_i,
    output logic                               status_interrupt_pin_n_o,
    output logic                               reset_complete_flag_o,
    output logic                               soft_reset_bit_o,
    output logic                               regs_reset_o,
    output logic                               dsp_run_o,
    output logic                               spi_active_o,
    output logic                               port_locked_o,
    output logic [7:0]                         port_lock_register_o,
    output logic [15:0]                        low_power_threshold_register_o,
    output logic [8:0]                         gain_register_o,
    output meter_reset_pkg::gain_sel_s         gain_sel_o,
    output meter_reset_pkg::adc_power_s        adc_power_o,
    output logic                               mod_clk_o,
    output logic [meter_reset_pkg::SAMPLE_WIDTH-1:0] sample_o,
    output logic                               sample_valid_o
);
    import meter_reset_pkg::*;

    if (RESET_LOW_CYC < 1 || TRANS_CYC < 1 || TRANS_CYC > 65535 ||
        RESET_LOW_CYC > 65535) begin : bad_counts
        $error("meter_reset_ctrl: count parameters out of range");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic       rst_pin_meta;
    logic       rst_pin_sync;
    logic       ss_meta;
    logic       ss_sync;
    logic       ss_prev;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rst_pin_meta <= 1'b1;
            rst_pin_sync <= 1'b1;
            ss_meta      <= 1'b1;
            ss_sync      <= 1'b1;
            ss_prev      <= 1'b1;
        end else begin
            rst_pin_meta <= reset_n_pin_i;
            rst_pin_sync <= rst_pin_meta;
            ss_meta      <= slave_select_pin_i;
            ss_sync      <= ss_meta;
            ss_prev      <= ss_sync;
        end
    end

    // ----------------------------------------------------------------
    // Reset sequencer
    // ----------------------------------------------------------------
    seq_state_e  state;
    seq_state_e  next_state;
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic        hw_kind;
    logic        next_hw_kind;

    wire full_power  = (power_mode_i == full_power_mode);
    wire pin_low     = full_power && !rst_pin_sync;                  // [RULE1] [RULE2]
    wire soft_req    = full_power && soft_reset_wr_i && soft_reset_data_i; // [RULE9] [RULE13]
    wire hold_done   = (cnt >= 16'(RESET_LOW_CYC - 1));
    wire trans_done  = (cnt == 16'(TRANS_CYC - 1));
    wire in_reset    = (state != ST_RUN);
    wire reset_end   = (state == ST_TRANSIT) && trans_done;
    wire hw_start    = (state == ST_RUN) && pin_low;
    wire sw_start    = (state == ST_RUN) && !pin_low && soft_req;

    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_hw_kind = hw_kind;
        unique case (state)
            ST_RUN: begin
                next_cnt = 16'h0000;
                if (hw_start) begin
                    next_state   = ST_HW_HOLD;
                    next_hw_kind = 1'b1;
                end else if (sw_start) begin
                    next_state   = ST_TRANSIT;
                    next_hw_kind = 1'b0;
                end
            end
            ST_HW_HOLD: begin
                // Short pulses are held off until the minimum low time
                if (!pin_low && hold_done) begin                     // [RULE3]
                    next_state = ST_TRANSIT;
                    next_cnt   = 16'h0000;
                end else if (!hold_done) begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            ST_TRANSIT: begin
                if (pin_low) begin
                    next_state   = ST_HW_HOLD;
                    next_hw_kind = 1'b1;
                    next_cnt     = 16'h0000;
                end else if (trans_done) begin
                    next_state = ST_RUN;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state   <= ST_RUN;
            cnt     <= 16'h0000;
            hw_kind <= 1'b0;
        end else begin
            state   <= next_state;
            cnt     <= next_cnt;
            hw_kind <= next_hw_kind;
        end
    end

    // ----------------------------------------------------------------
    // Registers and flags
    // ----------------------------------------------------------------
    wire hw_clear   = in_reset && hw_kind;
    wire done_clear = status_wr_i && status_data_i[RESET_DONE_BIT];  // [RULE5]
    wire writable   = !in_reset;
    wire ss_fall    = ss_sync == 1'b0 && ss_prev == 1'b1;
    logic [1:0] ss_count;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reset_complete_flag_o          <= 1'b0;
            status_interrupt_pin_n_o       <= 1'b1;
            soft_reset_bit_o               <= SOFT_RESET_DEFAULT;
            dsp_run_o                      <= 1'b0;
            gain_register_o                <= GAIN_REG_DEFAULT;
            port_lock_register_o           <= PORT_LOCK_DEFAULT;
            low_power_threshold_register_o <= LOW_POWER_THR_DEFAULT;
            regs_reset_o                   <= 1'b0;
        end else begin
            regs_reset_o <= in_reset;
            // Set wins over a clear arriving in the same cycle
            if (reset_end) begin
                reset_complete_flag_o <= 1'b1;                       // [RULE4] [RULE12]
            end else if (in_reset) begin
                reset_complete_flag_o <= 1'b0;                       // [RULE4]
            end else if (done_clear) begin
                reset_complete_flag_o <= 1'b0;                       // [RULE5]
            end
            // Unmaskable: pin follows the flag directly
            status_interrupt_pin_n_o <= !(reset_end ||
                (reset_complete_flag_o && !in_reset && !done_clear)); // [RULE21]
            if (sw_start) begin
                soft_reset_bit_o <= 1'b1;                            // [RULE9]
            end else if (reset_end || hw_clear) begin
                soft_reset_bit_o <= SOFT_RESET_DEFAULT;              // [RULE12]
            end
            if (in_reset) begin
                dsp_run_o       <= 1'b0;                             // [RULE6] [RULE13]
                gain_register_o <= GAIN_REG_DEFAULT;
            end else begin
                if (run_wr_i) begin
                    dsp_run_o <= run_data_i;                         // [RULE8]
                end
                if (gain_wr_i) begin
                    gain_register_o <= gain_data_i;
                end
            end
            // Only a hardware reset restores these two
            if (hw_clear) begin                                      // [RULE3] [RULE10]
                port_lock_register_o           <= PORT_LOCK_DEFAULT;
                low_power_threshold_register_o <= LOW_POWER_THR_DEFAULT;
            end else if (writable) begin
                if (port_lock_wr_i) begin
                    port_lock_register_o <= port_lock_data_i;
                end
                if (threshold_wr_i) begin
                    low_power_threshold_register_o <= threshold_data_i;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial port selection
    // ----------------------------------------------------------------
    wire lock_write = writable && port_lock_wr_i;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            spi_active_o  <= 1'b0;
            port_locked_o <= 1'b0;
            ss_count      <= 2'h0;
        end else if (hw_clear || (in_reset && !port_locked_o)) begin
            spi_active_o  <= 1'b0;                                   // [RULE7] [RULE11]
            port_locked_o <= 1'b0;
            ss_count      <= 2'h0;
        end else if (!in_reset) begin
            if (lock_write) begin
                port_locked_o <= 1'b1;
            end
            if (!port_locked_o && !spi_active_o && ss_fall) begin
                // Third falling edge of slave select selects SPI
                if (ss_count == 2'h2) begin                          // [RULE20]
                    spi_active_o <= 1'b1;
                end
                ss_count <= ss_count + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Gain decode and converter power
    // ----------------------------------------------------------------
    function automatic logic [4:0] gain_onehot(input logic [2:0] code);
        // Reserved codes fall back to unity gain
        gain_onehot = (code <= GAIN_CODE_MAX) ? 5'(5'h01 << code) : 5'h01; // [RULE22]
    endfunction

    wire [2:0] phase_code   = gain_register_o[PHASE_GAIN_LSB +: 3];   // [RULE14]
    wire [2:0] neutral_code = gain_register_o[NEUTRAL_GAIN_LSB +: 3]; // [RULE15]
    wire [2:0] voltage_code = gain_register_o[VOLTAGE_GAIN_LSB +: 3]; // [RULE16]
    wire       pw_phase     = power_mode_i == full_power_mode ||
                              power_mode_i == reduced_power_mode;     // [RULE17]

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_sel_o  <= '0;
            adc_power_o <= '0;
        end else begin
            gain_sel_o.phase_gain   <= gain_onehot(phase_code);
            gain_sel_o.neutral_gain <= gain_onehot(neutral_code);
            gain_sel_o.voltage_gain <= gain_onehot(voltage_code);
            adc_power_o.phase_on    <= pw_phase;                     // [RULE17]
            adc_power_o.neutral_on  <= full_power;
            adc_power_o.voltage_on  <= full_power;
        end
    end

    // ----------------------------------------------------------------
    // Modulator clock and averaging filter
    // ----------------------------------------------------------------
    // Divider runs off the system clock standing in for the master clock
    logic [3:0] div_cnt;
    logic       mod_bit_meta;
    logic       mod_bit_sync;
    logic [7:0] avg_cnt;
    logic [SAMPLE_WIDTH-1:0] ones;
    wire        mod_tick = (div_cnt == 4'(MOD_CLK_DIV - 1));           // [RULE18]
    wire        avg_last = (avg_cnt == 8'(FILTER_LEN - 1));

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt        <= 4'h0;
            mod_clk_o      <= 1'b0;
            mod_bit_meta   <= 1'b0;
            mod_bit_sync   <= 1'b0;
            avg_cnt        <= 8'h00;
            ones           <= '0;
            sample_o       <= '0;
            sample_valid_o <= 1'b0;
        end else begin
            div_cnt        <= mod_tick ? 4'h0 : div_cnt + 4'h1;
            mod_clk_o      <= div_cnt < 4'(MOD_CLK_DIV / 2);          // [RULE18]
            mod_bit_meta   <= mod_bit_i;
            mod_bit_sync   <= mod_bit_meta;
            sample_valid_o <= 1'b0;
            if (mod_tick) begin
                avg_cnt <= avg_cnt + 8'h01;
                if (avg_last) begin
                    // Half density maps to zero; a full window saturates
                    sample_o <= ones[8] ? 24'h7FFFFF :
                                SAMPLE_WIDTH'({ones[7:0], 16'h0000} - 24'h800000); // [RULE19]
                    sample_valid_o <= 1'b1;
                    ones <= SAMPLE_WIDTH'(mod_bit_sync);
                end else begin
                    ones <= ones + SAMPLE_WIDTH'(mod_bit_sync);      // [RULE19]
                end
            end
        end
    end

endmodule

// ===== rtl/meter_reset_pkg.sv
// Constants and carriers for the metering reset and gain control block.
// Assumes a single 40 MHz system clock; no register bus, all bits are ports.
package meter_reset_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ          = 40_000_000;
    localparam int unsigned RESET_LOW_MIN_NS    = 10_000;
    localparam int unsigned RESET_LOW_MIN_CYC   =
        (RESET_LOW_MIN_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned TRANSITION_CYC      = 64;
    localparam int unsigned MOD_CLK_DIV         = 16;
    localparam int unsigned FILTER_LEN          = 256;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned RESET_DONE_BIT      = 15;
    localparam int unsigned SOFT_RESET_BIT      = 7;
    localparam logic        SOFT_RESET_DEFAULT  = 1'b0;
    localparam int unsigned PHASE_GAIN_LSB      = 0;
    localparam int unsigned NEUTRAL_GAIN_LSB    = 3;
    localparam int unsigned VOLTAGE_GAIN_LSB    = 6;
    localparam logic [8:0]  GAIN_REG_DEFAULT    = 9'h000;
    localparam logic [2:0]  GAIN_CODE_MAX       = 3'h4;
    localparam logic [15:0] LOW_POWER_THR_DEFAULT = 16'h0000;
    localparam logic [7:0]  PORT_LOCK_DEFAULT   = 8'h00;
    localparam int unsigned SAMPLE_WIDTH        = 24;

    typedef enum logic [1:0] {
        full_power_mode    = 2'b00,
        reduced_power_mode = 2'b01,
        low_power_mode     = 2'b10,
        sleep_power_mode   = 2'b11
    } power_mode_e;

    typedef enum logic [1:0] {
        ST_RUN      = 2'b00,
        ST_HW_HOLD  = 2'b01,
        ST_TRANSIT  = 2'b10
    } seq_state_e;

    // Per-converter power enables and gains
    typedef struct packed {
        logic       phase_on;
        logic       neutral_on;
        logic       voltage_on;
    } adc_power_s;

    typedef struct packed {
        logic [4:0] phase_gain;
        logic [4:0] neutral_gain;
        logic [4:0] voltage_gain;
    } gain_sel_s;
endpackage

// ===== tb/host_model.sv
// Host-side model: drives the reset pin and the slave select pin.
// Assumes its tasks are called from the bench in the system clock domain.
`timescale 1ns/1ps
module host_model (
    input  wire logic clk_i,
    output logic      reset_n_pin_o,
    output logic      slave_select_pin_o
);
    initial begin
        reset_n_pin_o = 1'b1;
        slave_select_pin_o = 1'b1;
    end
    // Caller passes a low time at or above the device minimum
    task automatic pulse_reset(input int cycles);
        @(posedge clk_i) reset_n_pin_o <= 1'b0;
        repeat (cycles) @(posedge clk_i);
        reset_n_pin_o <= 1'b1;
    endtask
    // Slow toggles so the pin synchroniser sees every fall
    task automatic select_spi();
        repeat (3) begin
            @(posedge clk_i) slave_select_pin_o <= 1'b0;
            repeat (3) @(posedge clk_i);
            slave_select_pin_o <= 1'b1;
            repeat (3) @(posedge clk_i);
        end
    endtask
endmodule

// ===== tb/meter_reset_sva.sv
// Checker for the meter reset controller: flag, soft reset, gains, power.
// Assumes one clock; bound onto every instance of the controller.
`timescale 1ns/1ps
module meter_reset_sva (
    input  wire logic                         sys_clk_i,
    input  wire logic                         rst_i,
    input  wire meter_reset_pkg::power_mode_e power_mode_i,
    input  wire logic                         soft_reset_wr_i,
    input  wire logic                         soft_reset_data_i,
    input  wire logic                         status_wr_i,
    input  wire logic [15:0]                  status_data_i,
    input  wire logic                         status_interrupt_pin_n_o,
    input  wire logic                         reset_complete_flag_o,
    input  wire logic                         soft_reset_bit_o,
    input  wire logic                         regs_reset_o,
    input  wire logic [8:0]                   gain_register_o,
    input  wire meter_reset_pkg::gain_sel_s   gain_sel_o,
    input  wire meter_reset_pkg::adc_power_s  adc_power_o,
    input  wire logic                         mod_clk_o
);
    import meter_reset_pkg::*;
    localparam int SOFT_MAX = 300;
    logic [1:0] age;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // Registered outputs lag reset release; skip their first edges
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) age <= 2'h0;
        else if (age != 2'h3) age <= age + 2'h1;
    end
    function automatic logic [4:0] onehot(input logic [2:0] c);
        return (c > 3'h4) ? 5'h01 : (5'h01 << c);
    endfunction
    irq_follows_a: assert property (status_interrupt_pin_n_o == !reset_complete_flag_o)
        else $error("interrupt pin disagrees with done flag");
    flag_clear_a: assert property (reset_complete_flag_o && status_wr_i && status_data_i[15]
        |=> !reset_complete_flag_o) else $error("done flag not cleared");
    soft_go_a: assert property (soft_reset_wr_i && soft_reset_data_i &&
        power_mode_i == full_power_mode && !regs_reset_o && !soft_reset_bit_o
        |=> soft_reset_bit_o || regs_reset_o) else $error("soft reset not taken");
    soft_ignore_a: assert property (soft_reset_wr_i && power_mode_i != full_power_mode &&
        !soft_reset_bit_o |=> !soft_reset_bit_o) else $error("soft reset taken outside full");
    soft_end_a: assert property ($fell(soft_reset_bit_o)
        |-> reset_complete_flag_o && !status_interrupt_pin_n_o) else $error("soft end wrong");
    soft_bound_a: assert property ($rose(soft_reset_bit_o)
        |-> ##[1:SOFT_MAX] !soft_reset_bit_o) else $error("soft reset never ends");
    gain_map_a: assert property (age == 2'h3 && $stable(gain_register_o)
        |-> gain_sel_o == {onehot(gain_register_o[2:0]), onehot(gain_register_o[5:3]),
        onehot(gain_register_o[8:6])}) else $error("gain decode wrong");
    adc_power_a: assert property (age == 2'h3 && $stable(power_mode_i)
        |-> adc_power_o == {!power_mode_i[1], power_mode_i == full_power_mode,
        power_mode_i == full_power_mode}) else $error("converter power wrong");
    mod_clk_a: assert property ($rose(mod_clk_o)
        |-> mod_clk_o[*8] ##1 !mod_clk_o[*8]) else $error("modulator clock shape wrong");
endmodule

bind meter_reset_ctrl meter_reset_sva u_sva (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .power_mode_i(power_mode_i),
    .soft_reset_wr_i(soft_reset_wr_i), .soft_reset_data_i(soft_reset_data_i),
    .status_wr_i(status_wr_i), .status_data_i(status_data_i),
    .status_interrupt_pin_n_o(status_interrupt_pin_n_o),
    .reset_complete_flag_o(reset_complete_flag_o), .soft_reset_bit_o(soft_reset_bit_o),
    .regs_reset_o(regs_reset_o), .gain_register_o(gain_register_o),
    .gain_sel_o(gain_sel_o), .adc_power_o(adc_power_o), .mod_clk_o(mod_clk_o));

// ===== tb/tb_top.sv
// Self-checking bench for the meter reset controller.
// Assumes short reset counts (4 and 4) and the host model for pins.
`timescale 1ns/1ps
module tb_top;
    import meter_reset_pkg::*;
    localparam int LOW_CYC = 4;
    logic        clk, rst, rst_pin_n, ss_pin, mod_bit, sr_wr, sr_d, st_wr, pl_wr, th_wr, g_wr;
    logic        run_wr, run_d, irq_n, flag, sr_bit, regs_rst, dsp_run, spi, locked, mod_clk, sv;
    logic [15:0] st_d, th_d, thr_reg;
    logic [7:0]  pl_d, lock_reg;
    logic [8:0]  g_d, gain_reg;
    logic [23:0] sample;
    power_mode_e mode;
    gain_sel_s   gain_sel;
    adc_power_s  adc_pwr;
    int          miscompares = 0, tests_run = 0, cycles = 0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    host_model HOST (.clk_i(clk), .reset_n_pin_o(rst_pin_n), .slave_select_pin_o(ss_pin));
    meter_reset_ctrl #(.RESET_LOW_CYC(LOW_CYC), .TRANS_CYC(4)) DUT (
        .sys_clk_i(clk), .rst_i(rst), .reset_n_pin_i(rst_pin_n), .slave_select_pin_i(ss_pin),
        .power_mode_i(mode), .soft_reset_wr_i(sr_wr), .soft_reset_data_i(sr_d),
        .status_wr_i(st_wr), .status_data_i(st_d), .port_lock_wr_i(pl_wr),
        .port_lock_data_i(pl_d), .threshold_wr_i(th_wr), .threshold_data_i(th_d),
        .gain_wr_i(g_wr), .gain_data_i(g_d), .run_wr_i(run_wr), .run_data_i(run_d),
        .mod_bit_i(mod_bit), .status_interrupt_pin_n_o(irq_n), .reset_complete_flag_o(flag),
        .soft_reset_bit_o(sr_bit), .regs_reset_o(regs_rst), .dsp_run_o(dsp_run),
        .spi_active_o(spi), .port_locked_o(locked), .port_lock_register_o(lock_reg),
        .low_power_threshold_register_o(thr_reg), .gain_register_o(gain_reg),
        .gain_sel_o(gain_sel), .adc_power_o(adc_pwr), .mod_clk_o(mod_clk),
        .sample_o(sample), .sample_valid_o(sv));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Register write: 0 soft, 1 status, 2 lock, 3 threshold, 4 gain, 5 run
    task automatic wr(input int r, input logic [15:0] d);
        @(posedge clk);
        case (r)
            0: begin sr_wr <= 1'b1; sr_d <= d[0]; end
            1: begin st_wr <= 1'b1; st_d <= d; end
            2: begin pl_wr <= 1'b1; pl_d <= d[7:0]; end
            3: begin th_wr <= 1'b1; th_d <= d; end
            4: begin g_wr <= 1'b1; g_d <= d[8:0]; end
            default: begin run_wr <= 1'b1; run_d <= d[0]; end
        endcase
        @(posedge clk);
        {sr_wr, st_wr, pl_wr, th_wr, g_wr, run_wr} <= 6'h00;
        #1;
    endtask
    task automatic wait_flag();
        for (int n = 0; n < 200 && flag !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk(flag, 1'b1);
        chk(irq_n, 1'b0);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [4:0] ex_gain(input logic [2:0] c);
        return (c < 3'h5) ? (5'h01 << c) : 5'h01;
    endfunction

    task automatic t_hw();
        chk({flag, irq_n, sr_bit, dsp_run, spi}, 5'h08);
        HOST.select_spi();
        step(4);
        chk(spi, 1'b1);
        wr(3, 16'h1234);
        wr(2, 16'h00A5);
        wr(4, 16'h01FF);
        wr(5, 16'h0001);
        chk(dsp_run, 1'b1);
        HOST.pulse_reset(LOW_CYC + 2);
        step(1);
        chk(flag, 1'b0);
        wait_flag();
        chk({dsp_run, spi}, 2'h0);
        chk({thr_reg, lock_reg}, {LOW_POWER_THR_DEFAULT, PORT_LOCK_DEFAULT});
        chk(gain_reg, GAIN_REG_DEFAULT);
        wr(1, 16'h8000);
        chk({flag, irq_n}, 2'h1);
        @(posedge clk) mode <= reduced_power_mode;
        HOST.pulse_reset(LOW_CYC + 2);
        step(20);
        chk({flag, thr_reg}, 17'h00000);
        @(posedge clk) mode <= full_power_mode;
        $display("test hardware reset done");
    endtask
    task automatic t_soft();
        HOST.select_spi();
        wr(0, 16'h0001);
        wait_flag();
        chk(spi, 1'b0);
        HOST.select_spi();
        wr(3, 16'h5A5A);
        wr(2, 16'h0002);
        chk(locked, 1'b1);
        wr(4, 16'h0049);
        wr(5, 16'h0001);
        wr(0, 16'h0001);
        step(1);
        chk({sr_bit, flag}, 2'h2);
        wait_flag();
        chk({sr_bit, spi, dsp_run}, 3'h2);
        chk({thr_reg, lock_reg}, 24'h5A5A02);
        wr(1, 16'h8000);
        for (int m = 1; m < 4; m++) begin
            @(posedge clk) mode <= power_mode_e'(m[1:0]);
            wr(0, 16'h0001);
            chk(sr_bit, 1'b0);
            step(10);
            chk(flag, 1'b0);
        end
        @(posedge clk) mode <= full_power_mode;
        $display("test soft reset done");
    endtask
    task automatic t_gain_power();
        logic [2:0] p;
        for (int c = 0; c < 8; c++) begin
            p = c[2:0];
            wr(4, {7'h00, p + 3'h3, ~p, p});
            step(2);
            chk(gain_sel, {ex_gain(p), ex_gain(~p), ex_gain(p + 3'h3)});
        end
        for (int m = 0; m < 4; m++) begin
            @(posedge clk) mode <= power_mode_e'(m[1:0]);
            step(3);
            chk(adc_pwr, {m < 2, m == 0, m == 0});
        end
        @(posedge clk) mode <= full_power_mode;
        $display("test gain and power done");
    endtask
    // Cycles between two rises of the modulator clock or two sample pulses
    task automatic gap(input bit use_sv, output int n);
        logic prev, cur;
        int first;
        prev = 1'b1;
        first = -1;
        n = 0;
        for (int k = 0; k < 9000 && n == 0; k++) begin
            @(posedge clk);
            #1;
            cur = use_sv ? sv : mod_clk;
            if (cur === 1'b1 && (use_sv || prev === 1'b0)) begin
                if (first < 0) first = k;
                else n = k - first;
            end
            prev = cur;
        end
    endtask
    task automatic t_mod();
        int n;
        gap(1'b0, n);
        chk(n, MOD_CLK_DIV);
        gap(1'b1, n);
        chk(n, MOD_CLK_DIV * FILTER_LEN);
        chk(sample, 24'h7FFFFF);
        $display("test modulator done");
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Longest test is two filter periods; ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end
    initial begin
        rst = 1'b1;
        mode = full_power_mode;
        mod_bit = 1'b1;
        {sr_wr, sr_d, st_wr, pl_wr, th_wr, g_wr, run_wr, run_d} = 8'h00;
        {st_d, th_d, pl_d, g_d} = 49'h0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        step(1);
        t_hw();
        t_soft();
        t_gain_power();
        t_mod();
        conclude();
    end
endmodule
